// ### design/pim_coin_meter.sv
// coin-cell acquisition: waits for comparators to settle, then
// grades the cell against three thresholds
module pim_coin_meter #(
    parameter int SETTLE_CYC = pim_pkg::COIN_SETTLE_CYC
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // acquisition request
    input  wire logic       start_i,        // one-cycle start pulse
    // threshold comparators
    input  wire logic       above_low_i,
    input  wire logic       above_good_i,
    input  wire logic       above_ideal_i,
    // result
    output logic [1:0]      level_o,        // graded level
    output logic            busy_o          // acquisition running
);

    // elaboration check: the settle counter is only 16 bits wide
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
        $error("pim_coin_meter: SETTLE_CYC out of range");
    end

    // one-hot states
    typedef enum logic [1:0] {
        CM_IDLE   = 2'b01,
        CM_SETTLE = 2'b10
    } pim_cm_state_t;

    pim_cm_state_t state_r;   // current state
    pim_cm_state_t state_nxt; // next state
    logic [15:0]   cnt_r;     // settle counter
    logic [15:0]   cnt_nxt;
    logic [1:0]    level_r;   // last graded level
    logic [1:0]    level_nxt;
    logic [1:0]    grade;     // live grade of comparators

    // thermometer to code; a broken thermometer grades low,
    // which errs on the side of warning software
    always_comb begin
        if (above_ideal_i && above_good_i && above_low_i) begin
            grade = pim_pkg::COIN_IDEAL;
        end else if (above_good_i && above_low_i) begin
            grade = pim_pkg::COIN_GOOD;
        end else if (above_low_i) begin
            grade = pim_pkg::COIN_LOW;
        end else begin
            grade = pim_pkg::COIN_ABSENT;
        end
    end

    // sequencing; a start while busy is ignored
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        level_nxt = level_r;
        case (state_r)
            CM_IDLE: begin
                if (start_i) begin
                    state_nxt = CM_SETTLE;
                    cnt_nxt   = 16'(SETTLE_CYC - 1);
                end
            end
            CM_SETTLE: begin
                if (cnt_r == 16'h0000) begin
                    state_nxt = CM_IDLE;
                    level_nxt = grade;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            default: begin
                state_nxt = CM_IDLE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= CM_IDLE;
            cnt_r   <= 16'h0000;
            level_r <= pim_pkg::COIN_ABSENT;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;
    assign busy_o  = (state_r == CM_SETTLE);

endmodule : pim_coin_meter

// ### design/pim_flag_cell.sv
// one sticky event flag: raised by a level, cleared by a strobe
module pim_flag_cell (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // event and clear
    input  wire logic set_i,      // live event condition
    input  wire logic clr_i,      // clear strobe from a flag read
    // flag
    output logic      flag_o
);

    logic flag_r;   // stored flag
    logic flag_nxt; // next flag

    // a set in the clear cycle wins, so no event is lost
    always_comb begin
        flag_nxt = set_i | (flag_r & ~clr_i);
    end

    // registers only
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_o = flag_r;

endmodule : pim_flag_cell

// ### design/pim_irq_status.sv
// interrupt mask, event flags, status and control registers of the
// power controller, reached through the serial bus register port
module pim_irq_status #(
    parameter int SETTLE_CYC = pim_pkg::COIN_SETTLE_CYC
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // register port from the serial control bus
    input  wire logic [7:0] reg_addr_i,     // subaddress
    input  wire logic       reg_wr_i,       // write strobe
    input  wire logic [7:0] reg_wdata_i,    // write data
    input  wire logic       reg_rd_i,       // read strobe
    output logic [7:0]      reg_rdata_o,    // read data
    output logic            reg_rvalid_o,   // read data valid pulse
    // load switch monitors, index 0 is switch 1
    input  wire logic [2:0] switch_fault_i,
    input  wire logic [2:0] switch_ilimit_i,
    // system conditions
    input  wire logic       seal_broken_i,
    input  wire logic       nvm_modified_i,
    input  wire logic       mains_detect_input_n_i,
    input  wire logic       push_button_input_n_i,
    input  wire logic [1:0] power_state_i,
    // coin-cell comparators
    input  wire logic       coin_above_low_i,
    input  wire logic       coin_above_good_i,
    input  wire logic       coin_above_ideal_i,
    // outputs
    output logic            irq_out_n_o,        // active-low interrupt
    output logic            coin_acquire_busy_o,
    output logic            power_fail_off_o    // power-fail shutdown
);

    // elaboration check: the meter's settle counter is 16 bits wide
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
        $error("pim_irq_status: SETTLE_CYC out of range");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [5:0] mask_r;          // switch event mask bits
    logic [5:0] mask_nxt;
    logic       acq_start_r;     // self-clearing start bit
    logic       acq_start_nxt;
    logic       pfail_r;         // power-fail shutdown bit
    logic       pfail_nxt;
    logic       seal_r;          // seal state, zero from reset
    logic       seal_nxt;
    logic       nvm_r;           // defaults-modified state
    logic       nvm_nxt;
    logic [7:0] rdata_r;         // read data holding register
    logic [7:0] rdata_nxt;
    logic       rvalid_r;        // read answer pulse
    logic       rvalid_nxt;
    logic       irq_n_r;         // interrupt pin register
    logic       irq_n_nxt;
    logic       busy_r;          // acquisition busy, registered
    logic       busy_nxt;

    // decoded strobes
    logic       wr_mask;         // write to mask register
    logic       wr_ctrl;         // write to control register
    logic       rd_flags;        // read of flag register clears it

    // event flags and coin results from the sub-blocks
    logic [5:0] events;          // live monitor conditions
    logic [5:0] flags;           // sticky flags
    logic [1:0] coin_level;      // graded coin-cell level
    logic       coin_busy;       // meter still settling
    logic [7:0] status_word;     // assembled status value
    logic [7:0] ctrl_word;       // assembled control value

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        wr_mask  = reg_wr_i && (reg_addr_i == pim_pkg::ADDR_IRQ_MASK);
        wr_ctrl  = reg_wr_i && (reg_addr_i == pim_pkg::ADDR_CONTROL);
        rd_flags = reg_rd_i &&
                   (reg_addr_i == pim_pkg::ADDR_EVENT_FLAGS);
    end

    // ------------------------------------------------------------
    // event flags: monitors feed flags with no mask in the path
    // ------------------------------------------------------------
    always_comb begin
        events = 6'h00;
        // faults of switches 1..3 in bits 3..5
        events[pim_pkg::FAULT_LSB +: pim_pkg::NUM_SW] =
            switch_fault_i;
        // current limits of switches 1..3 in bits 0..2
        events[pim_pkg::ILIMIT_LSB +: pim_pkg::NUM_SW] =
            switch_ilimit_i;
    end

    // one sticky cell per event; the mask never reaches these, so
    // monitoring goes on while the pin is gated
    for (genvar g = 0; g < pim_pkg::EVENT_BITS; g++) begin : g_flag
        pim_flag_cell u_flag (
            .clk_i     (clk_i),
            .sys_rst_i (sys_rst_i),
            .set_i     (events[g]),
            .clr_i     (rd_flags),
            .flag_o    (flags[g])
        );
    end

    // ------------------------------------------------------------
    // coin-cell meter
    // ------------------------------------------------------------
    pim_coin_meter #(
        .SETTLE_CYC (SETTLE_CYC)
    ) u_coin (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .start_i       (acq_start_r),
        .above_low_i   (coin_above_low_i),
        .above_good_i  (coin_above_good_i),
        .above_ideal_i (coin_above_ideal_i),
        .level_o       (coin_level),
        .busy_o        (coin_busy)
    );

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    always_comb begin
        mask_nxt      = mask_r;
        pfail_nxt     = pfail_r;
        // start bit lives one cycle, then reads back as zero
        acq_start_nxt = 1'b0;
        if (wr_mask) begin
            // bits 7..6 are dropped: they stay read-only zero
            mask_nxt = reg_wdata_i[5:0];
        end
        if (wr_ctrl) begin
            pfail_nxt     = reg_wdata_i[pim_pkg::CTRL_PFAIL];
            acq_start_nxt = reg_wdata_i[pim_pkg::CTRL_ACQ];
        end
    end

    // ------------------------------------------------------------
    // interrupt pin: low while any flag is set and not masked
    // ------------------------------------------------------------
    always_comb begin
        // bit 5 fault 3, bit 4 fault 2, bit 3 fault 1,
        // bits 2..0 current limits 3..1
        irq_n_nxt = ~|(flags & ~mask_r);
    end

    // ------------------------------------------------------------
    // status assembly
    // ------------------------------------------------------------
    always_comb begin
        // seal and defaults-modified follow their inputs through a
        // register so they read zero straight out of reset
        seal_nxt = seal_broken_i;
        nvm_nxt  = nvm_modified_i;
        busy_nxt = coin_busy;
        status_word = 8'h00;
        status_word[pim_pkg::ST_SEAL]   = seal_r;
        status_word[pim_pkg::ST_NVM]    = nvm_r;
        // pins are active low; the status shows them active high
        status_word[pim_pkg::ST_MAINS]  =
            ~mains_detect_input_n_i;
        status_word[pim_pkg::ST_BUTTON] =
            ~push_button_input_n_i;
        status_word[pim_pkg::ST_STATE_LO +: 2] = power_state_i;
        // holds the last graded value; meaningless until software
        // has run an acquisition
        status_word[pim_pkg::ST_COIN_LO +: 2]  = coin_level;
    end

    // control readback, reserved bits zero
    always_comb begin
        ctrl_word = 8'h00;
        ctrl_word[pim_pkg::CTRL_PFAIL] = pfail_r;
        ctrl_word[pim_pkg::CTRL_ACQ]   = acq_start_r;
    end

    // ------------------------------------------------------------
    // read path: answer one cycle after the read strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = reg_rd_i;
        if (reg_rd_i) begin
            case (reg_addr_i)
                pim_pkg::ADDR_EVENT_FLAGS: begin
                    rdata_nxt = {2'b00, flags};
                end
                pim_pkg::ADDR_IRQ_MASK: begin
                    rdata_nxt = {2'b00, mask_r};
                end
                pim_pkg::ADDR_STATUS: begin
                    rdata_nxt = status_word;
                end
                pim_pkg::ADDR_CONTROL: begin
                    rdata_nxt = ctrl_word;
                end
                default: begin
                    // unmapped subaddress reads as zero
                    rdata_nxt = pim_pkg::UNMAPPED_DATA;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers only
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mask_r      <= pim_pkg::MASK_RESET;
            acq_start_r <= 1'b0;
            pfail_r     <= 1'b0;
            seal_r      <= 1'b0;
            nvm_r       <= 1'b0;
            rdata_r     <= pim_pkg::RDATA_RESET;
            rvalid_r    <= 1'b0;
            irq_n_r     <= 1'b1;
            busy_r      <= 1'b0;
        end else begin
            mask_r      <= mask_nxt;
            acq_start_r <= acq_start_nxt;
            pfail_r     <= pfail_nxt;
            seal_r      <= seal_nxt;
            nvm_r       <= nvm_nxt;
            rdata_r     <= rdata_nxt;
            rvalid_r    <= rvalid_nxt;
            irq_n_r     <= irq_n_nxt;
            busy_r      <= busy_nxt;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_o         = rdata_r;
    assign reg_rvalid_o        = rvalid_r;
    assign irq_out_n_o         = irq_n_r;
    assign coin_acquire_busy_o = busy_r;
    assign power_fail_off_o    = pfail_r;

endmodule : pim_irq_status

// ### design/pim_pkg.sv
// Notes on behaviour
// - mask register at 0x04, resets zero, top bits zero
// - mask bit 5 gates switch 3 fault
// - mask bit 4 gates switch 2 fault
// - mask bit 3 gates switch 1 fault
// - mask bits 2..0 gate current-limit events 3..1
// - unmasked event pulls interrupt output low
// - masking never stops flag updates
// - read-only status at 0x05, top bits reset zero
// - status bit 7 shows seal broken
// - status bit 6 shows defaults modified
// - status bit 5 set while mains pin low
// - status bit 4 set while button pin low
// - status bits 3..2 show power state
// - status bits 1..0 show coin-cell level
// - flag register 0x02: faults 5..3, limits 2..0
// - acquisition start bit triggers, then self-clears
package pim_pkg;

    // register subaddresses
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h02;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h04;
    localparam logic [7:0] ADDR_STATUS      = 8'h05;
    localparam logic [7:0] ADDR_CONTROL     = 8'h06;

    // values after reset
    localparam logic [5:0] MASK_RESET       = 6'h00;
    localparam logic [5:0] FLAGS_RESET      = 6'h00;
    localparam logic [1:0] CTRL_RESET       = 2'h0;
    localparam logic [7:0] RDATA_RESET      = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA    = 8'h00;

    // field positions, shared by flag and mask registers
    localparam int FAULT_LSB   = 3;   // faults of switches 1..3
    localparam int ILIMIT_LSB  = 0;   // current limits of switches 1..3
    localparam int NUM_SW      = 3;
    localparam int EVENT_BITS  = 6;

    // status register positions
    localparam int ST_SEAL     = 7;
    localparam int ST_NVM      = 6;
    localparam int ST_MAINS    = 5;
    localparam int ST_BUTTON   = 4;
    localparam int ST_STATE_LO = 2;
    localparam int ST_COIN_LO  = 0;

    // control register positions
    localparam int CTRL_ACQ    = 0;
    localparam int CTRL_PFAIL  = 1;

    // power state codes
    typedef enum logic [1:0] {
        PST_TRANSITION = 2'h0,
        PST_WAIT_EN    = 2'h1,
        PST_ACTIVE     = 2'h2,
        PST_SUSPEND    = 2'h3
    } pim_pwr_state_t;

    // coin-cell level codes
    typedef enum logic [1:0] {
        COIN_ABSENT = 2'h0,
        COIN_LOW    = 2'h1,
        COIN_GOOD   = 2'h2,
        COIN_IDEAL  = 2'h3
    } pim_coin_level_t;

    // comparator settling time and its cycle count at 100 MHz
    localparam int CLK_PERIOD_NS   = 10;
    localparam int COIN_SETTLE_NS  = 2000;
    localparam int COIN_SETTLE_CYC =
        (COIN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pim_pkg

// ### test/pim_host_model.sv
// host side of the register port: one-cycle strobes, launched at a
// rising edge and answered by a valid pulse on the next cycle
module pim_host_model (
    // clock
    input  wire logic       clk_i,
    // answers from the device
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i,
    // requests to the device
    output logic [7:0]      reg_addr_o,
    output logic            reg_wr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_rd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end

    // one write, strobe held for exactly one taking edge
    task write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge clk_i);
        reg_wr_o    <= 1'b0;
    endtask : write_reg

    // one read; data is taken mid-cycle while the valid pulse stands
    task read_reg(input logic [7:0] a, output logic [7:0] d,
                  output logic ok);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge clk_i);
        reg_rd_o   <= 1'b0;
        @(negedge clk_i);
        ok = reg_rvalid_i;
        d  = reg_rdata_i;
    endtask : read_reg

    // the coin level is only trusted after a measurement was started
    task acquire_coin;
        write_reg(pim_pkg::ADDR_CONTROL, 8'h03);
    endtask : acquire_coin
endmodule : pim_host_model

// ### test/pim_irq_status_sva.sv
// port-level checks of the mask, status and interrupt behaviour
module pim_irq_status_sva #(
    parameter int SETTLE_CYC = pim_pkg::COIN_SETTLE_CYC
) (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_rvalid_o,
    // monitored conditions
    input wire logic [2:0] switch_fault_i,
    input wire logic [2:0] switch_ilimit_i,
    input wire logic       seal_broken_i,
    input wire logic       mains_detect_input_n_i,
    input wire logic       push_button_input_n_i,
    input wire logic [1:0] power_state_i,
    // outputs
    input wire logic       irq_out_n_o,
    input wire logic       coin_acquire_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // slack on the settle bound, the meter reports one cycle late
    localparam int SETTLE_MAX = SETTLE_CYC + 4;

    logic [5:0] mask_sh_r;   // shadow of the mask, tracked from writes
    logic [5:0] mask_sh_nxt;
    logic       wr_mask;     // write to the mask this cycle
    logic       unm_ev;      // an event arrives that the mask lets pass

    assign wr_mask = reg_wr_i && (reg_addr_i == pim_pkg::ADDR_IRQ_MASK);
    assign unm_ev  = |({switch_fault_i, switch_ilimit_i} & ~mask_sh_r);

    // shadow next value: only a mask write changes it
    always_comb begin
        mask_sh_nxt = wr_mask ? reg_wdata_i[5:0] : mask_sh_r;
    end

    // shadow register, cleared with the design
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mask_sh_r <= 6'h00;
        end else begin
            mask_sh_r <= mask_sh_nxt;
        end
    end

    sequence s_rd_status;
        reg_rd_i && (reg_addr_i == pim_pkg::ADDR_STATUS);
    endsequence
    sequence s_rd_mask;
        reg_rd_i && (reg_addr_i == pim_pkg::ADDR_IRQ_MASK);
    endsequence

    property p_rvalid;
        reg_rd_i |=> reg_rvalid_o ##1 !reg_rvalid_o || $past(reg_rd_i);
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read valid pulse wrong");

    property p_mask_top;
        s_rd_mask |=> reg_rdata_o[7:6] == 2'h0;
    endproperty
    a_mask_top: assert property (p_mask_top)
        else $error("mask top bits not zero");

    property p_pins;
        s_rd_status |=> reg_rdata_o[5] == !$past(mains_detect_input_n_i)
            && reg_rdata_o[4] == !$past(push_button_input_n_i);
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin status bits wrong");

    property p_state;
        s_rd_status |=> reg_rdata_o[3:2] == $past(power_state_i);
    endproperty
    a_state: assert property (p_state)
        else $error("power state field wrong");

    property p_seal;
        s_rd_status ##0 !$past(sys_rst_i)
            |=> reg_rdata_o[7] == $past(seal_broken_i, 2);
    endproperty
    a_seal: assert property (p_seal)
        else $error("seal bit wrong");

    property p_irq_low;
        unm_ev && !wr_mask |-> ##2 !irq_out_n_o;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("unmasked event left interrupt high");

    property p_irq_fall;
        $fell(irq_out_n_o) |-> $past(unm_ev || wr_mask, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without unmasked cause");

    property p_busy_start;
        reg_wr_i && reg_addr_i == pim_pkg::ADDR_CONTROL && reg_wdata_i[0]
            && !coin_acquire_busy_o |-> ##[1:3] coin_acquire_busy_o;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("acquisition did not start");

    property p_busy_end;
        $rose(coin_acquire_busy_o) |-> ##[1:SETTLE_MAX] !coin_acquire_busy_o;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("acquisition did not finish");
endmodule : pim_irq_status_sva

bind pim_irq_status pim_irq_status_sva #(.SETTLE_CYC(SETTLE_CYC)) u_sva (
    .clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .reg_rvalid_o, .switch_fault_i, .switch_ilimit_i,
    .seal_broken_i, .mains_detect_input_n_i, .push_button_input_n_i,
    .power_state_i, .irq_out_n_o, .coin_acquire_busy_o
);

// ### test/pim_irq_status_tb_top.sv
// self-checking bench for the mask, flag, status and control port
module pim_irq_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_i, sys_rst_i, reg_wr, reg_rd, reg_rvalid, ok;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [2:0] sw_fault, sw_ilim;
    logic       seal, nvm, mains_n, button_n, c_low, c_good, c_ideal;
    logic       irq_n, busy, pfail;
    logic [1:0] pstate, coin_exp;  // coin level expected after measuring
    int         bad_count, samples_checked;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // short settle count keeps the coin tests quick
    pim_irq_status #(.SETTLE_CYC(4)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
        .switch_fault_i(sw_fault), .switch_ilimit_i(sw_ilim),
        .seal_broken_i(seal), .nvm_modified_i(nvm),
        .mains_detect_input_n_i(mains_n), .push_button_input_n_i(button_n),
        .power_state_i(pstate), .coin_above_low_i(c_low),
        .coin_above_good_i(c_good), .coin_above_ideal_i(c_ideal),
        .irq_out_n_o(irq_n), .coin_acquire_busy_o(busy),
        .power_fail_off_o(pfail));

    pim_host_model u_host (
        .clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid),
        .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
        .reg_rd_o(reg_rd));

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk

    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // read with a check that the valid pulse came
    task rd(input logic [7:0] a);
        u_host.read_reg(a, d, ok);
        chk("read valid", 8'h01, {7'h00, ok});
    endtask : rd

    task settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    // event i: 0..2 current limits, 3..5 faults, one cycle long
    task pulse(input int i);
        @(posedge clk_i);
        {sw_fault, sw_ilim} <= 6'h01 << i;
        @(posedge clk_i);
        {sw_fault, sw_ilim} <= 6'h00;
    endtask : pulse

    // bounded wait for the busy flag to reach a level
    task wait_busy(input logic lvl);
        for (int n = 0; n < 60 && busy !== lvl; n++) @(negedge clk_i);
        chk("busy wait", {7'h00, lvl}, {7'h00, busy});
        if (busy !== lvl) wrap_up();
    endtask : wait_busy

    function automatic logic [7:0] exp_status();
        return {seal, nvm, ~mains_n, ~button_n, pstate, coin_exp};
    endfunction : exp_status

    // reset, also in mid-run, then the reset values and unmapped reads
    task t_reset;
        // leave a nonzero mask and a pending interrupt for reset to undo
        u_host.write_reg(pim_pkg::ADDR_IRQ_MASK, 8'h2A);
        pulse(0);
        settle(2);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        coin_exp = 2'h0;
        rd(pim_pkg::ADDR_IRQ_MASK);
        chk("mask reset", 8'h00, d);
        chk("irq reset", 8'h01, {7'h00, irq_n});
        rd(pim_pkg::ADDR_EVENT_FLAGS);
        chk("flags reset", 8'h00, d);
        u_host.write_reg(8'h33, 8'hFF);
        rd(8'h33);
        chk("unmapped", 8'h00, d);
        u_host.write_reg(pim_pkg::ADDR_IRQ_MASK, 8'hFF);
        rd(pim_pkg::ADDR_IRQ_MASK);
        chk("mask rw", 8'h3F, d);
        $display("test reset done");
    endtask : t_reset

    // each event masked, then unmasked, flags read and cleared
    task t_gate;
        for (int i = 0; i < 6; i++) begin
            u_host.write_reg(pim_pkg::ADDR_IRQ_MASK, 8'h01 << i);
            pulse(i);
            settle(3);
            chk("irq masked", 8'h01, {7'h00, irq_n});
            rd(pim_pkg::ADDR_EVENT_FLAGS);
            chk("flag set", 8'h01 << i, d);
            rd(pim_pkg::ADDR_EVENT_FLAGS);
            chk("flag clear", 8'h00, d);
            u_host.write_reg(pim_pkg::ADDR_IRQ_MASK, 8'h00);
            pulse(i);
            settle(3);
            chk("irq unmasked", 8'h00, {7'h00, irq_n});
            rd(pim_pkg::ADDR_EVENT_FLAGS);
            settle(2);
            chk("irq release", 8'h01, {7'h00, irq_n});
        end
        $display("test gate done");
    endtask : t_gate

    // status bits follow the conditions; writes to it are ignored
    task t_status;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            seal     <= k[0];
            nvm      <= k[1];
            mains_n  <= k[0];
            button_n <= ~k[1];
            pstate   <= k[1:0];
            u_host.write_reg(pim_pkg::ADDR_STATUS, 8'h00);
            settle(2);
            rd(pim_pkg::ADDR_STATUS);
            chk("status", exp_status(), d);
        end
        $display("test status done");
    endtask : t_status

    // every coin grade, with the power-fail bit set alongside
    task t_coin;
        for (int lv = 0; lv < 4; lv++) begin
            @(posedge clk_i);
            c_low   <= (lv >= 1);
            c_good  <= (lv >= 2);
            c_ideal <= (lv >= 3);
            u_host.acquire_coin();
            wait_busy(1'b1);
            wait_busy(1'b0);
            coin_exp = lv[1:0];
            rd(pim_pkg::ADDR_STATUS);
            chk("coin level", exp_status(), d);
            rd(pim_pkg::ADDR_CONTROL);
            chk("control", 8'h02, d);
            chk("power fail", 8'h01, {7'h00, pfail});
        end
        $display("test coin done");
    endtask : t_coin

    initial begin
        bad_count = 0;
        samples_checked = 0;
        sys_rst_i = 1'b1;
        {sw_fault, sw_ilim} = 6'h00;
        {seal, nvm, mains_n, button_n, c_low, c_good, c_ideal} = 7'h0C;
        pstate = 2'h0;
        t_reset();
        t_gate();
        t_reset();
        t_status();
        t_coin();
        wrap_up();
    end
endmodule : pim_irq_status_tb_top
